// ==== src/cmpi_defines.vh ====
// Purpose: constants for the comparator control and change-flag block
// Assumes: AHB-Lite byte addresses equal to four times the register index
// Notes:   printed offsets are register indices
`ifndef CMPI_DEFINES_VH
`define CMPI_DEFINES_VH

`define CMPI_IDX_FLAGS2      8'h0d
`define CMPI_IDX_ENABLES2    8'h8d
`define CMPI_IDX_CMCTL       8'h9c
`define CMPI_IDX_REFCTL      8'h9d
`define CMPI_IDX_CORE_INT    8'h0b
`define CMPI_IDX_PORT_DATA   8'h05
`define CMPI_IDX_PORT_DIR    8'h85
`define CMPI_IDX_SLEEP       8'hf0

`define CMPI_RST_FLAGS2      8'h00
`define CMPI_RST_ENABLES2    8'h00
`define CMPI_RST_CMCTL       8'h07
`define CMPI_RST_REFCTL      8'h00
`define CMPI_RST_CORE_INT    8'h00
`define CMPI_RST_PORT_DIR    8'hff

`define CMPI_FLAGS2_MASK     8'he3
`define CMPI_REFCTL_MASK     8'hef

`define CMPI_BIT_RES2        7
`define CMPI_BIT_RES1        6
`define CMPI_BIT_INV2        5
`define CMPI_BIT_INV1        4
`define CMPI_BIT_CHG_FLAG    6
`define CMPI_BIT_CHG_EN      6
`define CMPI_BIT_GIE         7
`define CMPI_BIT_PERIPHERAL_IRQ_ENABLE        6
`define CMPI_BIT_PIN1        4
`define CMPI_BIT_PIN2        5

`define CMPI_MODE_REF        3'b110
`define CMPI_MODE_OFF        3'b111

`endif

// ==== src/cmpi_top.v ====
// Purpose: digital side of a dual comparator, with change flag and wake
// Assumes: one 100 MHz clock, AHB-Lite slave, single word transfers
// Notes:   zero wait states, answers OKAY always
//
// Design decision made here: register access over AHB-Lite.

`include "cmpi_defines.vh"

// What this block does
// - Results readable in bits 7:6, read-only
// - Routed pins carry unsynchronised comparator results
// - Direction bits still enable pin drivers
// - Bits 5:4 invert each result
// - Any result change sets change flag
// - Write 0 clears flag, 1 sets it
// - Request needs flag and three enables
// - Flag sets regardless of enables
// - Control register access updates reference copy
// - Persisting mismatch keeps setting the flag
// - Detection keeps working during sleep
// - Enabled comparator interrupt wakes from sleep
// - Waking leaves control register untouched
// - Reset loads control register with 0x07
// - Analog-input pins read zero on port data
// - Mode 110 routes internal reference
// - Result high when plus exceeds minus
module cmpi_top (
    input  wire        core_clk_i,
    input  wire        resetn_i,
    input  wire        hsel_i,
    input  wire [31:0] haddr_i,
    input  wire [1:0]  htrans_i,
    input  wire        hwrite_i,
    input  wire [2:0]  hsize_i,
    input  wire [31:0] hwdata_i,
    input  wire        hready_i,
    output reg  [31:0] hrdata_o,
    output reg         hreadyout_o,
    output reg         hresp_o,
    input  wire        cmp1_raw_i,
    input  wire        cmp2_raw_i,
    input  wire [7:0]  port_pins_i,
    input  wire [7:0]  analog_sel_i,
    output reg         first_output_pin_o,
    output reg         first_output_pin_oe_o,
    output reg         second_output_pin_o,
    output reg         second_output_pin_oe_o,
    output reg         route_enable_o,
    output reg  [2:0]  comparator_mode_field_o,
    output reg         ref_to_comparators_o,
    output reg  [7:0]  reference_generator_control_o,
    output reg         irq_o,
    output reg         wake_o
);

    reg  [1:0] rst_sync_q;
    wire       rst_n;
    reg  [1:0] res_meta_q;
    reg  [1:0] res_sync_q;
    reg  [1:0] ref_copy_q;
    reg  [7:0] cmctl_q;
    reg  [7:0] flags2_q;
    reg  [7:0] enables2_q;
    reg  [7:0] refctl_q;
    reg  [7:0] coreint_q;
    reg  [7:0] portdir_q;
    reg  [7:0] portout_q;
    reg        sleep_q;
    reg  [7:0] pins_meta_q;
    reg  [7:0] pins_sync_q;
    reg        dp_pend_q;
    reg        dp_write_q;
    reg  [7:0] dp_idx_q;
    wire [1:0] res_now;
    wire       mismatch;
    wire       ctl_touch;
    wire       wr_flags2;
    wire       irq_d;
    wire       addr_ok;
    reg  [7:0] rd_d;

    function [7:0] idx_of;
        input [31:0] a;
        begin
            idx_of = a[9:2];
        end
    endfunction

    always @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    always @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            res_meta_q  <= 2'b00;
            res_sync_q  <= 2'b00;
            pins_meta_q <= 8'h00;
            pins_sync_q <= 8'h00;
        end else begin
            res_meta_q  <= {cmp2_raw_i, cmp1_raw_i};
            res_sync_q  <= res_meta_q;
            pins_meta_q <= port_pins_i;
            pins_sync_q <= pins_meta_q;
        end
    end

    assign res_now = res_sync_q ^ {cmctl_q[`CMPI_BIT_INV2],
                                   cmctl_q[`CMPI_BIT_INV1]};
    assign mismatch = (res_now != ref_copy_q);

    // AHB-Lite data phase registers; address phase captured here
    assign addr_ok = hsel_i && hready_i && htrans_i[1];

    always @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            dp_pend_q  <= 1'b0;
            dp_write_q <= 1'b0;
            dp_idx_q   <= 8'h00;
        end else begin
            dp_pend_q  <= addr_ok;
            dp_write_q <= addr_ok && hwrite_i;
            dp_idx_q   <= addr_ok ? idx_of(haddr_i) : dp_idx_q;
        end
    end

    assign ctl_touch = (addr_ok && idx_of(haddr_i) == `CMPI_IDX_CMCTL) ||
                       (dp_pend_q && dp_idx_q == `CMPI_IDX_CMCTL);
    assign wr_flags2 = dp_write_q && dp_idx_q == `CMPI_IDX_FLAGS2;

    always @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            ref_copy_q <= 2'b00;
        end else if (ctl_touch) begin
            ref_copy_q <= res_now;
        end
    end

    always @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            cmctl_q    <= `CMPI_RST_CMCTL;
            enables2_q <= `CMPI_RST_ENABLES2;
            refctl_q   <= `CMPI_RST_REFCTL;
            coreint_q  <= `CMPI_RST_CORE_INT;
            portdir_q  <= `CMPI_RST_PORT_DIR;
            portout_q  <= 8'h00;
            sleep_q    <= 1'b0;
        end else begin
            if (dp_write_q) begin
                case (dp_idx_q)
                    `CMPI_IDX_CMCTL:
                        cmctl_q <= {2'b00, hwdata_i[5:0]};
                    `CMPI_IDX_ENABLES2:
                        enables2_q <= hwdata_i[7:0] & `CMPI_FLAGS2_MASK;
                    `CMPI_IDX_REFCTL:
                        refctl_q <= hwdata_i[7:0] & `CMPI_REFCTL_MASK;
                    `CMPI_IDX_CORE_INT:
                        coreint_q <= hwdata_i[7:0];
                    `CMPI_IDX_PORT_DIR:
                        portdir_q <= hwdata_i[7:0];
                    `CMPI_IDX_PORT_DATA:
                        portout_q <= hwdata_i[7:0];
                    `CMPI_IDX_SLEEP:
                        sleep_q <= hwdata_i[0];
                    default: begin
                    end
                endcase
            end else if (sleep_q && irq_d) begin
                sleep_q <= 1'b0;
            end
        end
    end

    always @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            flags2_q <= `CMPI_RST_FLAGS2;
        end else begin
            if (wr_flags2) begin
                flags2_q <= hwdata_i[7:0] & `CMPI_FLAGS2_MASK;
            end
            if (mismatch) begin
                flags2_q[`CMPI_BIT_CHG_FLAG] <= 1'b1;
            end
        end
    end

    assign irq_d = flags2_q[`CMPI_BIT_CHG_FLAG] &
                   enables2_q[`CMPI_BIT_CHG_EN] &
                   coreint_q[`CMPI_BIT_PERIPHERAL_IRQ_ENABLE] &
                   coreint_q[`CMPI_BIT_GIE];

    always @* begin
        case (dp_idx_q)
            `CMPI_IDX_CMCTL:     rd_d = {res_now, cmctl_q[5:0]};
            `CMPI_IDX_FLAGS2:    rd_d = flags2_q;
            `CMPI_IDX_ENABLES2:  rd_d = enables2_q;
            `CMPI_IDX_REFCTL:    rd_d = refctl_q;
            `CMPI_IDX_CORE_INT:  rd_d = coreint_q;
            `CMPI_IDX_PORT_DIR:  rd_d = portdir_q;
            `CMPI_IDX_PORT_DATA: rd_d = pins_sync_q & ~analog_sel_i;
            `CMPI_IDX_SLEEP:     rd_d = {7'h00, sleep_q};
            default:             rd_d = 8'h00;
        endcase
    end

    // Read data held registered for the cycle after address phase
    always @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            hrdata_o    <= 32'h0000_0000;
            hreadyout_o <= 1'b1;
            hresp_o     <= 1'b0;
        end else begin
            hreadyout_o <= 1'b1;
            hresp_o     <= 1'b0;
            hrdata_o    <= addr_ok && !hwrite_i ?
                           {24'h00_0000, rd_sel(idx_of(haddr_i))} :
                           hrdata_o;
        end
    end

    function [7:0] rd_sel;
        input [7:0] i;
        begin
            case (i)
                `CMPI_IDX_CMCTL:     rd_sel = {res_now, cmctl_q[5:0]};
                `CMPI_IDX_FLAGS2:    rd_sel = flags2_q;
                `CMPI_IDX_ENABLES2:  rd_sel = enables2_q;
                `CMPI_IDX_REFCTL:    rd_sel = refctl_q;
                `CMPI_IDX_CORE_INT:  rd_sel = coreint_q;
                `CMPI_IDX_PORT_DIR:  rd_sel = portdir_q;
                `CMPI_IDX_PORT_DATA: rd_sel = pins_sync_q & ~analog_sel_i;
                `CMPI_IDX_SLEEP:     rd_sel = {7'h00, sleep_q};
                default:             rd_sel = 8'h00;
            endcase
        end
    endfunction

    // Outputs, all registered; routed pin value lags the raw result a cycle
    always @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            first_output_pin_o            <= 1'b0;
            first_output_pin_oe_o         <= 1'b0;
            second_output_pin_o           <= 1'b0;
            second_output_pin_oe_o        <= 1'b0;
            route_enable_o                <= 1'b0;
            comparator_mode_field_o       <= `CMPI_MODE_OFF;
            ref_to_comparators_o          <= 1'b0;
            reference_generator_control_o <= `CMPI_RST_REFCTL;
            irq_o                         <= 1'b0;
            wake_o                        <= 1'b0;
        end else begin
            first_output_pin_o  <= route_enable_o ?
                (cmp1_raw_i ^ cmctl_q[`CMPI_BIT_INV1]) :
                portout_q[`CMPI_BIT_PIN1];
            second_output_pin_o <= route_enable_o ?
                (cmp2_raw_i ^ cmctl_q[`CMPI_BIT_INV2]) :
                portout_q[`CMPI_BIT_PIN2];
            first_output_pin_oe_o  <= ~portdir_q[`CMPI_BIT_PIN1];
            second_output_pin_oe_o <= ~portdir_q[`CMPI_BIT_PIN2];
            route_enable_o          <= cmctl_q[3];
            comparator_mode_field_o <= cmctl_q[2:0];
            ref_to_comparators_o <= (cmctl_q[2:0] == `CMPI_MODE_REF);
            reference_generator_control_o <= refctl_q;
            irq_o  <= irq_d;
            wake_o <= sleep_q && irq_d;
        end
    end

endmodule // cmpi_top

// ==== dv/cmpi_props_properties.sv ====
// Purpose: port checks for the comparator block
// Assumes: one register between raw result and routed pin
// Notes:   bound to every cmpi_top
module cmpi_props (
    input wire logic       core_clk_i, resetn_i, cmp1_raw_i, cmp2_raw_i,
    input wire logic       first_output_pin_o, second_output_pin_o,
    input wire logic       route_enable_o, ref_to_comparators_o,
    input wire logic       irq_o, wake_o,
    input wire logic [2:0] comparator_mode_field_o,
    input wire logic [7:0] reference_generator_control_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);
    sequence s_routed; route_enable_o [*4]; endsequence
    sequence s_fresh; $rose(resetn_i); endsequence
    property p_off; s_fresh |-> comparator_mode_field_o == 3'b111; endproperty
    a_off: assert property (p_off) else $error("mode not off");
    property p_noroute; s_fresh |-> !route_enable_o; endproperty
    a_noroute: assert property (p_noroute) else $error("route on");
    property p_quiet; s_fresh |-> (!irq_o && !wake_o) [*4]; endproperty
    a_quiet: assert property (p_quiet) else $error("early irq");
    property p_ref;
        ref_to_comparators_o == (comparator_mode_field_o == 3'b110);
    endproperty
    a_ref: assert property (p_ref) else $error("ref select");
    property p_rsv; reference_generator_control_o[4] == 1'b0; endproperty
    a_rsv: assert property (p_rsv) else $error("ref bit4 set");
    property p_wake; wake_o |=> !wake_o; endproperty
    a_wake: assert property (p_wake) else $error("wake too long");
    // Inversion held still while routed
    property p_pin1;
        s_routed ##0 $past(cmp1_raw_i) != $past(cmp1_raw_i, 2)
            |-> $changed(first_output_pin_o);
    endproperty
    a_pin1: assert property (p_pin1) else $error("pin1 stuck");
    property p_pin2;
        s_routed ##0 $past(cmp2_raw_i) != $past(cmp2_raw_i, 2)
            |-> $changed(second_output_pin_o);
    endproperty
    a_pin2: assert property (p_pin2) else $error("pin2 stuck");
endmodule // cmpi_props

bind cmpi_top cmpi_props u_props (.core_clk_i, .resetn_i, .cmp1_raw_i,
    .cmp2_raw_i, .first_output_pin_o, .second_output_pin_o, .route_enable_o,
    .ref_to_comparators_o, .irq_o, .wake_o, .comparator_mode_field_o,
    .reference_generator_control_o);

// ==== dv/cmpi_core_model.sv ====
// Purpose: far side: two analog comparators and the core wake count
// Assumes: input levels are unsigned codes
// Notes:   results move just after a clock edge
module cmpi_core_model (
    input  wire logic       clk_i, wake_i,
    input  wire logic [7:0] plus1_i, minus1_i, plus2_i, minus2_i,
    output logic            res1_o = 1'b0,
    output logic            res2_o = 1'b0,
    output int              wakes_o = 0
);
    timeunit 1ns;
    timeprecision 100ps;
    always @(posedge clk_i) begin
        res1_o <= plus1_i > minus1_i;
        res2_o <= plus2_i > minus2_i;
        if (wake_i === 1'b1)
            wakes_o <= wakes_o + 1;
    end
endmodule // cmpi_core_model

// ==== dv/tb_top.sv ====
// Purpose: self-checking bench for the comparator block
// Assumes: zero-wait slave, byte address four times index
// Notes:   levels drawn from one fixed seed
`include "cmpi_defines.vh"
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [7:0] i_ctl = `CMPI_IDX_CMCTL, i_ref = `CMPI_IDX_REFCTL;
    localparam logic [7:0] i_flg = `CMPI_IDX_FLAGS2, i_en = `CMPI_IDX_ENABLES2;
    localparam logic [7:0] i_int = `CMPI_IDX_CORE_INT, i_slp = `CMPI_IDX_SLEEP;
    localparam logic [7:0] i_prt = `CMPI_IDX_PORT_DATA;
    localparam logic [7:0] i_dir = `CMPI_IDX_PORT_DIR;
    logic core_clk_i, resetn_i, hwrite_i, hsel_i = 1'b1;
    logic [1:0] htrans_i;
    logic [2:0] hsize_i = 3'b010;
    logic [31:0] haddr_i, hwdata_i, rd;
    logic [7:0] port_pins_i, analog_sel_i, p1, m1, p2, m2, w;
    wire logic [31:0] hrdata_o;
    wire logic hreadyout_o, hresp_o, cmp1_raw_i, cmp2_raw_i, irq_o, wake_o;
    wire logic first_output_pin_o, first_output_pin_oe_o, route_enable_o;
    wire logic second_output_pin_o, second_output_pin_oe_o;
    wire logic ref_to_comparators_o;
    wire logic [2:0] comparator_mode_field_o;
    wire logic [7:0] reference_generator_control_o;
    int n_mismatch, total_checks, wakes, n0;

    cmpi_top DUT (.core_clk_i, .resetn_i, .hsel_i, .haddr_i, .htrans_i,
        .hwrite_i, .hsize_i, .hwdata_i, .hready_i(hreadyout_o), .hrdata_o,
        .hreadyout_o, .hresp_o, .cmp1_raw_i, .cmp2_raw_i, .port_pins_i,
        .analog_sel_i, .first_output_pin_o, .first_output_pin_oe_o,
        .second_output_pin_o, .second_output_pin_oe_o, .route_enable_o,
        .comparator_mode_field_o, .ref_to_comparators_o,
        .reference_generator_control_o, .irq_o, .wake_o);
    cmpi_core_model u_core (.clk_i(core_clk_i), .wake_i(wake_o), .plus1_i(p1),
        .minus1_i(m1), .plus2_i(p2), .minus2_i(m2), .res1_o(cmp1_raw_i),
        .res2_o(cmp2_raw_i), .wakes_o(wakes));

    function automatic logic [7:0] ctl_exp(logic [7:0] v);
        return {(p2 > m2) ^ v[5], (p1 > m1) ^ v[4], v[5:0]};
    endfunction
    task automatic chk(input logic [31:0] g, e);
        total_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Bounded wait for the slave's ready
    task automatic rdy;
        for (int n = 0; n < 40; n++) begin
            @(posedge core_clk_i);
            if (hreadyout_o === 1'b1)
                return;
        end
        n_mismatch++;
        report_and_stop();
    endtask
    task automatic xfer(input logic wr, input logic [7:0] idx, d);
        htrans_i <= 2'b10;
        hwrite_i <= wr;
        haddr_i <= {22'h0, idx, 2'b00};
        rdy();
        htrans_i <= 2'b00;
        hwdata_i <= {24'h0, d};
        rdy();
        rd = hrdata_o;
    endtask
    task automatic rchk(input logic [7:0] idx, e);
        xfer(1'b0, idx, 8'h00);
        chk(rd, {24'h0, e});
    endtask
    task automatic lev(input logic [7:0] a, b, c, d);
        p1 <= a;
        m1 <= b;
        p2 <= c;
        m2 <= d;
        repeat (5) @(posedge core_clk_i);
    endtask

    initial begin
        core_clk_i = 1'b0;
        forever #5 core_clk_i = ~core_clk_i;
    end
    initial begin
        {resetn_i, hwrite_i, htrans_i, haddr_i, hwdata_i} = '0;
        {port_pins_i, analog_sel_i, p1, p2} = '0;
        {m1, m2} = {8'h40, 8'h40};
        w = 8'($urandom(32'h6ec9212c));
        repeat (6) @(posedge core_clk_i);
        resetn_i <= 1'b1;
        repeat (3) @(posedge core_clk_i);
        rchk(i_ctl, 8'h07);
        rchk(i_dir, 8'hff);
        xfer(1'b1, 8'h60, 8'hff);
        rchk(8'h60, 8'h00);
        $display("test reset done");
        for (int k = 0; k < 8; k++) begin
            w = {2'b11, 2'(k), 1'b0, 3'($urandom)};
            lev(8'($urandom), 8'($urandom), 8'($urandom), 8'($urandom));
            xfer(1'b1, i_ctl, w);
            rchk(i_ctl, ctl_exp(w));
        end
        $display("test results done");
        lev(8'h10, 8'h40, 8'h10, 8'h40);
        xfer(1'b1, i_ctl, 8'h02);
        rchk(i_ctl, 8'h02);
        xfer(1'b1, i_flg, 8'h00);
        rchk(i_flg, 8'h00);
        lev(8'h90, 8'h40, 8'h10, 8'h40);
        rchk(i_flg, 8'h40);
        chk(32'(irq_o), 32'd0);
        xfer(1'b1, i_flg, 8'h00);
        rchk(i_flg, 8'h40);
        rchk(i_ctl, 8'h42);
        xfer(1'b1, i_flg, 8'h00);
        rchk(i_flg, 8'h00);
        $display("test change done");
        xfer(1'b1, i_flg, 8'h40);
        rchk(i_flg, 8'h40);
        for (int k = 0; k < 8; k++) begin
            xfer(1'b1, i_en, {1'b0, k[0], 6'h00});
            xfer(1'b1, i_int, {k[2:1], 6'h00});
            repeat (2) @(posedge core_clk_i);
            chk(32'(irq_o), 32'(k == 7));
        end
        xfer(1'b1, i_flg, 8'h00);
        repeat (2) @(posedge core_clk_i);
        chk(32'(irq_o), 32'd0);
        $display("test gating done");
        xfer(1'b1, i_ctl, 8'h12);
        rchk(i_ctl, ctl_exp(8'h12));
        xfer(1'b1, i_flg, 8'h00);
        xfer(1'b1, i_ctl, 8'h17);
        n0 = wakes;
        xfer(1'b1, i_slp, 8'h01);
        lev(8'h90, 8'h40, 8'h90, 8'h40);
        for (int n = 0; n < 20 && wakes == n0; n++)
            @(posedge core_clk_i);
        chk(32'(wakes - n0), 32'd1);
        if (wakes == n0)
            report_and_stop();
        chk(32'(irq_o), 32'd1);
        rchk(i_slp, 8'h00);
        rchk(i_ctl, ctl_exp(8'h17));
        xfer(1'b1, i_en, 8'h00);
        $display("test sleep done");
        xfer(1'b1, i_dir, 8'hcf);
        w = {2'b00, 2'($urandom), 4'b1010};
        xfer(1'b1, i_ctl, w);
        repeat (3) @(posedge core_clk_i);
        chk(32'({second_output_pin_oe_o, first_output_pin_oe_o}), 32'd3);
        for (int k = 0; k < 4; k++) begin
            lev(8'($urandom), 8'($urandom), 8'($urandom), 8'($urandom));
            chk(32'({second_output_pin_o, first_output_pin_o}),
                32'({(p2 > m2) ^ w[5], (p1 > m1) ^ w[4]}));
        end
        xfer(1'b1, i_dir, 8'hff);
        repeat (3) @(posedge core_clk_i);
        chk(32'({second_output_pin_oe_o, first_output_pin_oe_o}), 32'd0);
        xfer(1'b1, i_ctl, 8'h02);
        port_pins_i <= 8'($urandom);
        analog_sel_i <= 8'($urandom);
        repeat (4) @(posedge core_clk_i);
        rchk(i_prt, port_pins_i & ~analog_sel_i);
        $display("test pins done");
        xfer(1'b1, i_ctl, 8'h06);
        repeat (2) @(posedge core_clk_i);
        chk(32'(ref_to_comparators_o), 32'd1);
        w = 8'($urandom);
        xfer(1'b1, i_ref, w);
        rchk(i_ref, w & `CMPI_REFCTL_MASK);
        chk(32'(reference_generator_control_o), 32'(w & 8'hef));
        $display("test reference done");
        lev(8'h10, 8'h40, 8'h10, 8'h40);
        xfer(1'b1, i_ctl, 8'h35);
        resetn_i <= 1'b0;
        repeat (2) @(posedge core_clk_i);
        resetn_i <= 1'b1;
        repeat (3) @(posedge core_clk_i);
        rchk(i_ctl, 8'h07);
        $display("test second reset done");
        report_and_stop();
    end
endmodule // tb_top
